// ==== src/adc_config_register_bank.sv ====
// Configuration register bank with decoded control outputs
//
// Function
// [RULE1] Rate field bits 7:5 chosen per mode
// [RULE2] Mode field: normal, duty-cycle, turbo, reserved
// [RULE3] Bit 2 selects single-shot or continuous
// [RULE4] Temperature mode ignores register 0, internal reference
// [RULE5] Bit 0 enables burn-out current sources
// [RULE6] Rate table per mode, code 111 reserved
// [RULE7] Rates hold at 4.096 MHz, scale otherwise
// [RULE8] Bits 7:6 pick reference source
// [RULE9] Bits 5:4 pick line rejection filter
// [RULE10] Host uses rejection only at slowest rates
// [RULE11] Low-side switch follows start and power-down
// [RULE12] Bits 2:0 set excitation current level
// [RULE13] Bits 7:5 route first current source
// [RULE14] Bits 4:2 route second current source
// [RULE15] Bit 1 adds ready on shared pin
// [RULE16] Three RW registers at 01h-03h, reset 00h
// [RULE17] Access only via read and write commands
// [RULE18] Write command end restarts the filter
// [RULE19] Retain in power-down, clear on reset
// [RULE20] Host writes no reserved codes or bits
// [RULE21] Reads return last write, no side effect
`timescale 1ns/10ps
module adc_config_register_bank (
   input  wire logic                      core_clk,
   input  wire logic                      nrst,
   input  wire adc_cfg_pkg::reg_req_type  reg_req,
   input  wire logic                      write_done,
   input  wire logic                      start_sync_cmd,
   input  wire logic                      power_down_command,
   input  wire logic                      data_ready_n,
   output logic [7:0]                     reg_rdata,
   output logic                           reg_rvalid,
   output logic [12:0]                    rate_quarter_sps,
   output logic [9:0]                     mod_clk_khz,
   output logic                           duty_cycle_en,
   output logic                           config_reserved,
   output logic                           continuous_conversion_select,
   output logic                           temperature_sensor_enable,
   output logic                           input_config_ignore,
   output logic                           burnout_source_enable,
   output logic [1:0]                     ref_select,
   output logic [1:0]                     line_reject_select,
   output logic                           low_side_switch_closed,
   output logic [10:0]                    excitation_current_level,
   output logic [5:0]                     first_current_route,
   output logic [5:0]                     second_current_route,
   output logic                           filter_restart,
   output logic                           dedicated_ready_pin_n,
   output logic                           shared_ready_n
);
   logic [7:0]                rate_mode_control_r;
   logic [7:0]                reference_filter_excitation_r;
   logic [7:0]                current_routing_ready_mode_r;
   adc_cfg_pkg::sw_state_type sw_state_r;
   adc_cfg_pkg::op_mode_type  mode;
   logic [2:0]                rate_code;
   logic [2:0]                idac_code;
   logic [2:0]                route_code [0:1];
   logic [5:0]                route_onehot [0:1];
   logic                      ready_on_data_pin;
   logic                      low_side_switch_mode;

   // Field extraction
   assign mode      = adc_cfg_pkg::op_mode_type'(
      rate_mode_control_r[adc_cfg_pkg::MODE_MSB:adc_cfg_pkg::MODE_LSB]);
   assign rate_code = rate_mode_control_r[adc_cfg_pkg::RATE_MSB:adc_cfg_pkg::RATE_LSB];
   assign idac_code =
      reference_filter_excitation_r[adc_cfg_pkg::IDAC_MSB:adc_cfg_pkg::IDAC_LSB];
   assign route_code[0] =
      current_routing_ready_mode_r[adc_cfg_pkg::ROUTE1_MSB:adc_cfg_pkg::ROUTE1_LSB];
   assign route_code[1] =
      current_routing_ready_mode_r[adc_cfg_pkg::ROUTE2_MSB:adc_cfg_pkg::ROUTE2_LSB];
   assign ready_on_data_pin    = current_routing_ready_mode_r[adc_cfg_pkg::RDYM_BIT];
   assign low_side_switch_mode = reference_filter_excitation_r[adc_cfg_pkg::SW_BIT];

   // Register writes; power-down touches nothing here, so values are kept
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rate_mode_control_r           <= adc_cfg_pkg::CFG_RESET; // [RULE16] [RULE19]
         reference_filter_excitation_r <= adc_cfg_pkg::CFG_RESET; // [RULE16] [RULE19]
         current_routing_ready_mode_r  <= adc_cfg_pkg::CFG_RESET; // [RULE16] [RULE19]
      end else if (reg_req.wr) begin
         // Reserved bits are stored as written so readback is exact
         case (reg_req.addr)
            adc_cfg_pkg::RATE_MODE_OFS: begin
               rate_mode_control_r <= reg_req.wdata; // [RULE16] [RULE17]
            end
            adc_cfg_pkg::REF_FILT_OFS: begin
               reference_filter_excitation_r <= reg_req.wdata; // [RULE16] [RULE17]
            end
            adc_cfg_pkg::ROUTE_RDY_OFS: begin
               current_routing_ready_mode_r <= reg_req.wdata; // [RULE16] [RULE17]
            end
            default: begin
            end
         endcase
      end
   end

   // Readback; offset 0 belongs to another bank and reads zero here
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_req.rd; // [RULE17]
         if (reg_req.rd) begin
            case (reg_req.addr)
               adc_cfg_pkg::RATE_MODE_OFS: reg_rdata <= rate_mode_control_r; // [RULE21]
               adc_cfg_pkg::REF_FILT_OFS:  reg_rdata <= reference_filter_excitation_r;
               adc_cfg_pkg::ROUTE_RDY_OFS: reg_rdata <= current_routing_ready_mode_r;
               default:                    reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // Rate and modulator decode; rates are nominal at the reference clock
   // and scale with the external clock outside this bank
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rate_quarter_sps <= 13'h0000;
         mod_clk_khz      <= 10'h000;
         duty_cycle_en    <= 1'b0;
      end else begin
         duty_cycle_en <= (mode == adc_cfg_pkg::MODE_DUTY); // [RULE2]
         case (mode)
            adc_cfg_pkg::MODE_TURBO: mod_clk_khz <= adc_cfg_pkg::MOD_CLK_TURBO_KHZ; // [RULE2]
            adc_cfg_pkg::MODE_RSVD:  mod_clk_khz <= 10'h000;
            default:                 mod_clk_khz <= adc_cfg_pkg::MOD_CLK_NORMAL_KHZ;
         endcase
         if (rate_code == adc_cfg_pkg::RATE_RSVD_CODE) begin
            rate_quarter_sps <= 13'h0000; // [RULE6]
         end else begin
            case (mode) // [RULE1] [RULE7]
               adc_cfg_pkg::MODE_NORMAL:
                  rate_quarter_sps <= adc_cfg_pkg::RATE_NORMAL_Q[rate_code]; // [RULE6]
               adc_cfg_pkg::MODE_DUTY:
                  rate_quarter_sps <= adc_cfg_pkg::RATE_DUTY_Q[rate_code];
               adc_cfg_pkg::MODE_TURBO:
                  rate_quarter_sps <= adc_cfg_pkg::RATE_TURBO_Q[rate_code];
               default:
                  rate_quarter_sps <= 13'h0000;
            endcase
         end
      end
   end

   // Flag for any reserved code, so the datapath can hold off
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         config_reserved <= 1'b0;
      end else begin
         config_reserved <= (mode == adc_cfg_pkg::MODE_RSVD)
            || (rate_code == adc_cfg_pkg::RATE_RSVD_CODE)
            || (idac_code == adc_cfg_pkg::IDAC_RSVD_A)
            || (idac_code == adc_cfg_pkg::IDAC_RSVD_B)
            || (route_code[0] == adc_cfg_pkg::ROUTE_RSVD)
            || (route_code[1] == adc_cfg_pkg::ROUTE_RSVD)
            || current_routing_ready_mode_r[adc_cfg_pkg::RSVD_BIT]; // [RULE20]
      end
   end

   // Conversion, sensor and reference controls
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         continuous_conversion_select <= 1'b0;
         temperature_sensor_enable    <= 1'b0;
         input_config_ignore          <= 1'b0;
         burnout_source_enable        <= 1'b0;
         ref_select                   <= 2'h0;
         line_reject_select           <= 2'h0;
         excitation_current_level     <= 11'h000;
      end else begin
         continuous_conversion_select <= rate_mode_control_r[adc_cfg_pkg::CONT_BIT]; // [RULE3]
         temperature_sensor_enable    <= rate_mode_control_r[adc_cfg_pkg::TEMP_BIT]; // [RULE4]
         input_config_ignore          <= rate_mode_control_r[adc_cfg_pkg::TEMP_BIT]; // [RULE4]
         burnout_source_enable        <= rate_mode_control_r[adc_cfg_pkg::BURN_BIT]; // [RULE5]
         // Temperature mode forces the internal reference (code 00)
         if (rate_mode_control_r[adc_cfg_pkg::TEMP_BIT]) begin
            ref_select <= 2'h0; // [RULE4]
         end else begin
            ref_select <= reference_filter_excitation_r[adc_cfg_pkg::REF_MSB:adc_cfg_pkg::REF_LSB];
         end // [RULE8]
         // Passed as written; pairing it with a legal rate is the host's job
         line_reject_select <=
            reference_filter_excitation_r[adc_cfg_pkg::LINE_MSB:adc_cfg_pkg::LINE_LSB]; // [RULE9]
         excitation_current_level <= adc_cfg_pkg::IDAC_UA[idac_code]; // [RULE12]
      end
   end

   // Current routing for both sources, one-hot over six destinations
   generate
      for (genvar s = 0; s < 2; s++) begin : g_route
         always_comb begin
            route_onehot[s] = 6'h00;
            if (route_code[s] != 3'h0 && route_code[s] != adc_cfg_pkg::ROUTE_RSVD) begin
               route_onehot[s][route_code[s] - 3'h1] = 1'b1; // [RULE13] [RULE14]
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         first_current_route  <= 6'h00;
         second_current_route <= 6'h00;
      end else begin
         first_current_route  <= route_onehot[0]; // [RULE13]
         second_current_route <= route_onehot[1]; // [RULE14]
      end
   end

   // Low-side switch; power-down wins if both commands arrive together
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sw_state_r <= adc_cfg_pkg::SW_OPEN;
      end else begin
         case (sw_state_r)
            adc_cfg_pkg::SW_OPEN: begin
               if (low_side_switch_mode && start_sync_cmd && !power_down_command) begin
                  sw_state_r <= adc_cfg_pkg::SW_CLOSED; // [RULE11]
               end
            end
            adc_cfg_pkg::SW_CLOSED: begin
               if (!low_side_switch_mode || power_down_command) begin
                  sw_state_r <= adc_cfg_pkg::SW_OPEN; // [RULE11]
               end
            end
            default: sw_state_r <= adc_cfg_pkg::SW_OPEN;
         endcase
      end
   end
   assign low_side_switch_closed = (sw_state_r == adc_cfg_pkg::SW_CLOSED);

   // Filter restart once the whole write command has been taken
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         filter_restart <= 1'b0;
      end else begin
         filter_restart <= write_done; // [RULE18]
      end
   end

   // Ready pins; the shared pin only joins in when enabled
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dedicated_ready_pin_n <= 1'b1;
         shared_ready_n        <= 1'b1;
      end else begin
         dedicated_ready_pin_n <= data_ready_n;                       // [RULE15]
         shared_ready_n        <= data_ready_n | !ready_on_data_pin;  // [RULE15]
      end
   end

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence wr_rate_s;
      reg_req.wr && reg_req.addr == adc_cfg_pkg::RATE_MODE_OFS;
   endsequence
   sequence sw_start_s;
      low_side_switch_mode && start_sync_cmd && !power_down_command;
   endsequence

   write_update_a: assert property (wr_rate_s |=> // [RULE16]
      rate_mode_control_r == $past(reg_req.wdata))
      else $error("rate register not updated by write");
   read_back_a: assert property (reg_req.rd && !reg_req.wr // [RULE21]
      && reg_req.addr == adc_cfg_pkg::REF_FILT_OFS |=>
      reg_rvalid && reg_rdata == reference_filter_excitation_r)
      else $error("readback differs from stored value");
   read_quiet_a: assert property (reg_req.rd && !reg_req.wr |=> // [RULE21]
      $stable(rate_mode_control_r) && $stable(current_routing_ready_mode_r))
      else $error("read changed a register");
   temp_mode_a: assert property ((wr_rate_s and reg_req.wdata[adc_cfg_pkg::TEMP_BIT]) // [RULE4]
      ##1 (!reg_req.wr)[*1] |=> input_config_ignore && ref_select == 2'h0)
      else $error("temperature mode not forcing internal reference");
   turbo_clk_a: assert property (mode == adc_cfg_pkg::MODE_TURBO |=> // [RULE2]
      mod_clk_khz == 10'h200 && !duty_cycle_en)
      else $error("turbo mode clock wrong");
   rate_min_a: assert property (mode == adc_cfg_pkg::MODE_DUTY && rate_code == 3'h0 |=> // [RULE6]
      rate_quarter_sps == 13'h0014)
      else $error("duty-cycle slowest rate wrong");
   switch_close_a: assert property (sw_start_s |=> low_side_switch_closed // [RULE11]
      ##0 (low_side_switch_closed || power_down_command)[*1])
      else $error("switch did not close on start");
   switch_open_a: assert property (!low_side_switch_mode |=> !low_side_switch_closed) // [RULE11]
      else $error("switch closed while disabled");
   restart_a: assert property (write_done |=> filter_restart) // [RULE18]
      else $error("filter not restarted after write");
   shared_rdy_a: assert property (!ready_on_data_pin |=> shared_ready_n) // [RULE15]
      else $error("shared pin signalled ready while disabled");
   idac_max_a: assert property (idac_code == 3'h7 |=> // [RULE12]
      excitation_current_level == 11'h5DC)
      else $error("largest excitation current wrong");
   route_first_a: assert property (route_code[0] == 3'h1 && route_code[1] == 3'h6 |=> // [RULE13]
      first_current_route == 6'h01 ##0 second_current_route == 6'h20)
      else $error("first source routing wrong");
endmodule

// ==== src/adc_cfg_pkg.sv ====
// Shared constants, types and tables of the configuration register bank
package adc_cfg_pkg;
   // Register offsets
   localparam logic [1:0] RATE_MODE_OFS   = 2'h1;
   localparam logic [1:0] REF_FILT_OFS    = 2'h2;
   localparam logic [1:0] ROUTE_RDY_OFS   = 2'h3;
   localparam logic [7:0] CFG_RESET       = 8'h00;
   // Field positions, rate/mode register
   localparam int RATE_MSB = 7;
   localparam int RATE_LSB = 5;
   localparam int MODE_MSB = 4;
   localparam int MODE_LSB = 3;
   localparam int CONT_BIT = 2;
   localparam int TEMP_BIT = 1;
   localparam int BURN_BIT = 0;
   // Field positions, reference/filter/excitation register
   localparam int REF_MSB  = 7;
   localparam int REF_LSB  = 6;
   localparam int LINE_MSB = 5;
   localparam int LINE_LSB = 4;
   localparam int SW_BIT   = 3;
   localparam int IDAC_MSB = 2;
   localparam int IDAC_LSB = 0;
   // Field positions, routing/ready register
   localparam int ROUTE1_MSB = 7;
   localparam int ROUTE1_LSB = 5;
   localparam int ROUTE2_MSB = 4;
   localparam int ROUTE2_LSB = 2;
   localparam int RDYM_BIT   = 1;
   localparam int RSVD_BIT   = 0;
   // Operating modes
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_DUTY   = 2'b01,
      MODE_TURBO  = 2'b10,
      MODE_RSVD   = 2'b11
   } op_mode_type;
   // Low-side switch states
   typedef enum logic [0:0] {
      SW_OPEN   = 1'b0,
      SW_CLOSED = 1'b1
   } sw_state_type;
   // Modulator clock in kHz
   localparam logic [9:0] MOD_CLK_NORMAL_KHZ = 10'h100;
   localparam logic [9:0] MOD_CLK_TURBO_KHZ  = 10'h200;
   // Reference clock at which the rate table holds, in kHz
   localparam int RATE_REF_CLK_KHZ = 4096;
   // Data rates in quarter samples per second, codes 000 to 110
   typedef logic [12:0] rate_tab_type [0:6];
   localparam rate_tab_type RATE_NORMAL_Q = '{13'h0050, 13'h00B4, 13'h0168,
      13'h02BC, 13'h0528, 13'h0960, 13'h0FA0};
   localparam rate_tab_type RATE_DUTY_Q = '{13'h0014, 13'h002D, 13'h005A,
      13'h00B0, 13'h014A, 13'h0258, 13'h03E8};
   localparam rate_tab_type RATE_TURBO_Q = '{13'h00A0, 13'h0168, 13'h02D0,
      13'h0578, 13'h0A50, 13'h12C0, 13'h1F40};
   localparam logic [2:0] RATE_RSVD_CODE = 3'h7;
   // Excitation current per code in microamps, zero for off or reserved
   typedef logic [10:0] idac_tab_type [0:7];
   localparam idac_tab_type IDAC_UA = '{11'h000, 11'h000, 11'h032, 11'h000,
      11'h0FA, 11'h1F4, 11'h3E8, 11'h5DC};
   localparam logic [2:0] IDAC_RSVD_A = 3'h1;
   localparam logic [2:0] IDAC_RSVD_B = 3'h3;
   localparam logic [2:0] ROUTE_RSVD  = 3'h7;
   // Register request from the command decoder
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [1:0] addr;
      logic [7:0] wdata;
   } reg_req_type;
endpackage

// ==== tb/host_cmd_model.sv ====
// Host-side command decoder model driving register requests and commands
`timescale 1ns/10ps
module host_cmd_model (
   input  wire logic                     core_clk,
   input  wire logic [7:0]               reg_rdata,
   input  wire logic                     reg_rvalid,
   output adc_cfg_pkg::reg_req_type      reg_req,
   output logic                          write_done,
   output logic                          start_sync_cmd,
   output logic                          power_down_command
);
   // Idle bus at time zero
   initial begin
      reg_req = '0;
      write_done = 1'b0;
      start_sync_cmd = 1'b0;
      power_down_command = 1'b0;
   end

   // One write command, completion pulse follows the byte
   task automatic write_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      reg_req.wr = 1'b1;
      reg_req.addr = a;
      reg_req.wdata = d;
      @(posedge core_clk);
      #1;
      reg_req.wr = 1'b0;
      reg_req.wdata = ~d; // Released data shows no stale value
      write_done = 1'b1;
      @(posedge core_clk);
      #1;
      write_done = 1'b0;
   endtask

   // One read command, answer taken in the cycle it stands
   task automatic read_reg(input logic [1:0] a, output logic [7:0] d, output logic ok);
      @(posedge core_clk);
      #1;
      reg_req.rd = 1'b1;
      reg_req.addr = a;
      @(posedge core_clk);
      #1;
      reg_req.rd = 1'b0;
      ok = reg_rvalid;
      d = reg_rdata;
   endtask

   // Start and power-down pulses, both at once only on purpose
   task automatic pulse_cmd(input logic s, input logic p);
      @(posedge core_clk);
      #1;
      start_sync_cmd = s;
      power_down_command = p;
      @(posedge core_clk);
      #1;
      start_sync_cmd = 1'b0;
      power_down_command = 1'b0;
   endtask
endmodule

// ==== tb/adc_config_register_bank_tb_top.sv ====
// Self-checking bench of the configuration register bank
`timescale 1ns/10ps
module adc_config_register_bank_tb_top;
   typedef struct {
      logic [7:0]  wd;
      logic [12:0] rate;
      logic [9:0]  mclk;
      logic [5:0]  fl;
   } row_type;
   adc_cfg_pkg::reg_req_type reg_req;
   logic        core_clk, nrst, data_ready_n, write_done, start_sync_cmd, power_down_command;
   logic        reg_rvalid, rd_ok, duty_cycle_en, config_reserved, continuous_conversion_select;
   logic        temperature_sensor_enable, input_config_ignore, burnout_source_enable;
   logic        low_side_switch_closed, filter_restart, dedicated_ready_pin_n, shared_ready_n;
   logic [7:0]  reg_rdata, rd_val;
   logic [12:0] rate_quarter_sps;
   logic [9:0]  mod_clk_khz;
   logic [1:0]  ref_select, line_reject_select;
   logic [10:0] excitation_current_level;
   logic [5:0]  first_current_route, second_current_route, exp_route;
   int          err_total, num_checks, cyc;
   // Flags are {duty, reserved, continuous, temperature, ignore, burn-out}
   row_type     rows [0:10] = '{'{8'hC0, 13'h0FA0, 10'h100, 6'h00},
      '{8'h08, 13'h0014, 10'h100, 6'h20}, '{8'hC8, 13'h03E8, 10'h100, 6'h20},
      '{8'hB0, 13'h12C0, 10'h200, 6'h00}, '{8'hD0, 13'h1F40, 10'h200, 6'h00},
      '{8'h18, 13'h0000, 10'h000, 6'h10}, '{8'hE0, 13'h0000, 10'h100, 6'h10},
      '{8'h04, 13'h0050, 10'h100, 6'h08}, '{8'h02, 13'h0050, 10'h100, 6'h06},
      '{8'h01, 13'h0050, 10'h100, 6'h01}, '{8'h00, 13'h0050, 10'h100, 6'h00}};
   logic [10:0] idac_ua [0:7] = '{11'h000, 11'h000, 11'h032, 11'h000,
      11'h0FA, 11'h1F4, 11'h3E8, 11'h5DC};

   adc_config_register_bank i_dut (.core_clk, .nrst, .reg_req, .write_done, .start_sync_cmd,
      .power_down_command, .data_ready_n, .reg_rdata, .reg_rvalid, .rate_quarter_sps,
      .mod_clk_khz, .duty_cycle_en, .config_reserved, .continuous_conversion_select,
      .temperature_sensor_enable, .input_config_ignore, .burnout_source_enable, .ref_select,
      .line_reject_select, .low_side_switch_closed, .excitation_current_level,
      .first_current_route, .second_current_route, .filter_restart, .dedicated_ready_pin_n,
      .shared_ready_n);
   host_cmd_model i_host (.core_clk, .reg_rdata, .reg_rvalid, .reg_req, .write_done,
      .start_sync_cmd, .power_down_command);

   // Clock and hang guard; a run needs well under a thousand cycles
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
      i_host.read_reg(a, rd_val, rd_ok);
      chk(16'({rd_ok, rd_val}), 16'({1'b1, exp}));
   endtask
   task automatic sw_chk(input logic s, input logic p, input logic exp);
      i_host.pulse_cmd(s, p);
      @(posedge core_clk);
      #1;
      chk(16'(low_side_switch_closed), 16'(exp));
   endtask
   task automatic do_reset();
      nrst = 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      nrst = 1'b1;
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Main sequence: reset values first, then table rows, then the awkward cases
   initial begin
      nrst = 1'b0;
      data_ready_n = 1'b1;
      err_total = 0;
      num_checks = 0;
      cyc = 0;
      do_reset();
      for (int a = 1; a < 4; a++) rd_chk(2'(a), 8'h00);
      chk(16'({rate_quarter_sps, 3'b000}), 16'h0280);
      foreach (rows[i]) begin
         i_host.write_reg(adc_cfg_pkg::RATE_MODE_OFS, rows[i].wd);
         chk(16'(filter_restart), 16'h0001);
         chk(16'(rate_quarter_sps), 16'(rows[i].rate));
         chk(16'(mod_clk_khz), 16'(rows[i].mclk));
         chk(16'({duty_cycle_en, config_reserved, continuous_conversion_select,
            temperature_sensor_enable, input_config_ignore, burnout_source_enable}),
            16'(rows[i].fl));
         rd_chk(adc_cfg_pkg::RATE_MODE_OFS, rows[i].wd);
      end
      // Rate is now 20 SPS normal, so line rejection is allowed
      for (int c = 0; c < 8; c++) begin
         i_host.write_reg(adc_cfg_pkg::REF_FILT_OFS, {4'h6, 1'b0, 3'(c)});
         chk(16'(excitation_current_level), 16'(idac_ua[c]));
         chk(16'({ref_select, line_reject_select, config_reserved}),
            16'({4'h6, 1'(c == 1 || c == 3)}));
      end
      for (int c = 0; c < 8; c++) begin
         i_host.write_reg(adc_cfg_pkg::ROUTE_RDY_OFS, {3'(c), 3'(7 - c), 2'b00});
         exp_route = (c == 0 || c == 7) ? 6'h00 : 6'(1 << (c - 1));
         chk(16'(first_current_route), 16'(exp_route));
         exp_route = (c == 0 || c == 7) ? 6'h00 : 6'(1 << (6 - c));
         chk(16'(second_current_route), 16'(exp_route));
      end
      // Reserved bit is kept and flagged; the host never does this otherwise
      i_host.write_reg(adc_cfg_pkg::ROUTE_RDY_OFS, 8'h01);
      chk(16'(config_reserved), 16'h0001);
      rd_chk(adc_cfg_pkg::ROUTE_RDY_OFS, 8'h01);
      data_ready_n = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk(16'({dedicated_ready_pin_n, shared_ready_n}), 16'h0001);
      i_host.write_reg(adc_cfg_pkg::ROUTE_RDY_OFS, 8'h02);
      chk(16'({dedicated_ready_pin_n, shared_ready_n}), 16'h0000);
      data_ready_n = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      chk(16'({dedicated_ready_pin_n, shared_ready_n}), 16'h0003);
      // Low-side switch: ignored start, close, open, power-down winning a tie
      i_host.write_reg(adc_cfg_pkg::REF_FILT_OFS, 8'h00);
      sw_chk(1'b1, 1'b0, 1'b0);
      i_host.write_reg(adc_cfg_pkg::REF_FILT_OFS, 8'h08);
      sw_chk(1'b1, 1'b0, 1'b1);
      sw_chk(1'b0, 1'b1, 1'b0);
      sw_chk(1'b1, 1'b0, 1'b1);
      sw_chk(1'b1, 1'b1, 1'b0);
      sw_chk(1'b1, 1'b1, 1'b0);
      // Temperature mode overrides the written reference
      i_host.write_reg(adc_cfg_pkg::REF_FILT_OFS, 8'hC0);
      i_host.write_reg(adc_cfg_pkg::RATE_MODE_OFS, 8'h02);
      chk(16'({ref_select, input_config_ignore}), 16'h0001);
      i_host.write_reg(adc_cfg_pkg::RATE_MODE_OFS, 8'h00);
      chk(16'({ref_select, input_config_ignore}), 16'h0006);
      // Offset zero is outside this bank and must not disturb it
      i_host.write_reg(2'h0, 8'h5A);
      rd_chk(2'h0, 8'h00);
      i_host.pulse_cmd(1'b0, 1'b1);
      rd_chk(adc_cfg_pkg::REF_FILT_OFS, 8'hC0);
      do_reset();
      rd_chk(adc_cfg_pkg::REF_FILT_OFS, 8'h00);
      tally_and_finish();
   end
endmodule
